// ==== design/spi_flags_data.sv ====
// Summary of operation
// - Buffered: done flag sets as shifter empties, none queued; 1 clears.
// - Unbuffered: data write during an active byte sets write collision.
// - Collision clears only by flag read while set, then data access.
// - Buffered: tx-empty reads 1 once the buffer empties into the shifter, 0 while byte waits.
// - Tx-empty resets to 0; reads 0 outside buffered mode.
// - Every data write clears tx-empty; nothing else clears it.
// - Tx-empty interrupt stays asserted while flag and its enable are set.
// - Select low drops master mode unless disabled; buffered: also sets flag.
// - Buffered: third byte with both rx entries full sets overflow.
// - With no tx data pending, overflow waits for next transfer start.
// - Overflow holds until the data register is read.
// - Data write with no byte active starts a transfer shifting that byte out.
// - Buffered data read returns second entry, moves first into second.
// - Buffered mode gives two rx entries, one tx entry, split flags.
// - Unbuffered: general flag sets each completed byte.
`timescale 1ns/1ps
`default_nettype none
module spi_flags_data #(
  parameter int HALF_CYC = spi_flags_pkg::SCK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                               clk_in,
  input  wire logic                               srst_in,
  // Avalon-MM slave
  input  wire logic [spi_flags_pkg::ADDR_W-1:0]   avs_address_in,
  input  wire logic                               avs_read_in,
  input  wire logic                               avs_write_in,
  input  wire logic [3:0]                         avs_byteenable_in,
  input  wire logic [31:0]                        avs_writedata_in,
  output logic      [31:0]                        avs_readdata_out,
  output logic                                    avs_waitrequest_out,
  // Interrupt
  output logic                                    irq_out,
  // Serial link
  input  wire logic                               sck_in,
  input  wire logic                               select_n_in,
  input  wire logic                               sdi_in,
  output logic                                    sck_out,
  output logic                                    sck_oe_out,
  output logic                                    sdo_out,
  output logic                                    sdo_oe_out
);
  import spi_flags_pkg::*;

  // Divider is eight bits wide
  if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_half_cyc_check
    $error("HALF_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, answer on the second edge
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  rd_mux;
  wire acc      = avs_read_in | avs_write_in;
  wire do_wr    = avs_write_in & ack_ff & avs_byteenable_in[0];
  wire do_rd    = avs_read_in & ack_ff;
  wire hit_ctrl = reg_hit(avs_address_in, OFS_CTRL);
  wire hit_data = reg_hit(avs_address_in, OFS_DATA);
  wire hit_flag = reg_hit(avs_address_in, OFS_FLAGS);
  wire hit_mask = reg_hit(avs_address_in, OFS_MASK);
  wire hit_evt  = reg_hit(avs_address_in, OFS_EVENTS);
  wire data_wr  = do_wr & hit_data;
  wire data_rd  = do_rd & hit_data;
  wire data_acc = acc & ack_ff & hit_data;
  wire flag_rd  = do_rd & hit_flag;
  wire flag_wr  = do_wr & hit_flag;
  wire [7:0] wbyte = avs_writedata_in[7:0];

  assign avs_waitrequest_out = acc & ~ack_ff;
  assign avs_readdata_out    = rdata_ff;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= acc & ~ack_ff;
      if (avs_read_in & ~ack_ff) begin
        rdata_ff <= {24'h000000, rd_mux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins into the clock domain
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  link_sync #(.W(3), .RESET_VAL(3'h2)) u_sync (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .async_in  ({sdi_in, select_n_in, sck_in}),
    .level_out (pin_lvl),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // State
  ctrl_t       ctrl_ff;
  flags_t      mask_ff;
  flags_t      evt_ff;
  link_state_t state_ff;
  logic [7:0]  tx_sh_ff, rx_sh_ff, tx_buf_ff, rx_last_ff;
  logic [7:0]  rx_mem_ff [RX_DEPTH];
  logic [1:0]  rx_cnt_ff;
  logic [2:0]  bit_cnt_ff;
  logic [7:0]  div_ff;
  logic        sck_ff, tx_full_ff, tx_empty_ff, xfer_done_ff;
  logic        write_collision_ff, wc_arm_ff, gen_ff, gen_arm_ff;
  logic        select_trigger_ff, rx_overflow_ff, ovf_pend_ff;

  wire buf_mode = ctrl_ff.buffered_mode_enable;
  wire master   = ctrl_ff.master & ctrl_ff.enable;
  wire selected = ~pin_lvl[1] & ctrl_ff.enable & ~ctrl_ff.master;
  wire busy     = (state_ff == LINK_SHIFT) | (bit_cnt_ff != FIRST_BIT);

  // Master clock divider runs only while a byte is out or sck is high
  wire run  = master & ((state_ff == LINK_SHIFT) | sck_ff);
  wire tick = run & (div_ff == 8'(HALF_CYC - 1));
  wire sample_ev = master ? (tick & ~sck_ff) : (pin_rise[0] & selected);
  wire shift_ev  = master ? (tick & sck_ff) : (pin_fall[0] & selected);
  wire [7:0] rx_byte = {rx_sh_ff[6:0], pin_lvl[2]};
  wire byte_done  = sample_ev & (bit_cnt_ff == LAST_BIT);
  wire xfer_start = sample_ev & (bit_cnt_ff == FIRST_BIT);

  // Select pulled low while master and not disabled
  wire sel_trig = master & ~pin_lvl[1] & ~ctrl_ff.select_disable;

  // Load of the shifter from bus or tx buffer
  wire direct_ld = data_wr & ~buf_mode & ~busy;
  wire move_ld   = buf_mode & tx_full_ff &
                   ((state_ff == LINK_IDLE) | byte_done);
  wire load      = direct_ld | move_ld;
  wire [7:0] ld_val = direct_ld ? wbyte : tx_buf_ff;
  wire wc_set  = data_wr & ~buf_mode & busy;
  wire txc_set = buf_mode & byte_done & ~tx_full_ff & ~data_wr;

  assign sck_out    = sck_ff;
  assign sck_oe_out = master;
  assign sdo_out    = tx_sh_ff[7];
  assign sdo_oe_out = master | selected;

  ////////////////////////////////////////////////////////////////////////
  // Receive entries: [1] is the older byte, handed out first
  logic [7:0] nxt_mem0, nxt_mem1;
  logic [1:0] nxt_rx_cnt;
  logic       ovf_hit;
  wire pop  = data_rd & buf_mode & (rx_cnt_ff != RX_EMPTY);
  wire push = byte_done & buf_mode;
  wire [1:0] cnt_p = rx_cnt_ff - {1'b0, pop};

  always_comb begin
    nxt_mem0   = rx_mem_ff[0];
    nxt_mem1   = pop ? rx_mem_ff[0] : rx_mem_ff[1];
    nxt_rx_cnt = cnt_p;
    ovf_hit    = 1'b0;
    if (push) begin
      if (cnt_p == RX_EMPTY) begin
        nxt_mem1   = rx_byte;
        nxt_rx_cnt = RX_ONE;
      end else if (cnt_p == RX_ONE) begin
        nxt_mem0   = rx_byte;
        nxt_rx_cnt = RX_FULL;
      end else begin
        ovf_hit = 1'b1;
      end
    end
  end

  // Loss shows at once if tx data waits, else at the next transfer
  wire ovf_now = ovf_hit & (tx_full_ff | load);
  wire ovf_set = ovf_now | (ovf_pend_ff & xfer_start);

  ////////////////////////////////////////////////////////////////////////
  // Flag view and read mux
  flags_t view;
  assign view.rx     = buf_mode ? (rx_cnt_ff != RX_EMPTY) : gen_ff;
  assign view.txc    = buf_mode ? xfer_done_ff : write_collision_ff;
  assign view.dre    = buf_mode & tx_empty_ff;
  assign view.sel    = buf_mode & select_trigger_ff;
  assign view.unused = 3'h0;
  assign view.ovf    = buf_mode & rx_overflow_ff;

  wire [7:0] data_view = buf_mode ? rx_mem_ff[1] : rx_last_ff;
  assign rd_mux = hit_ctrl ? {4'h0, ctrl_ff} :
                  hit_data ? data_view :
                  hit_flag ? view :
                  hit_mask ? mask_ff :
                  hit_evt  ? evt_ff : BYTE_ZERO;

  flags_t evt_new;
  assign evt_new.rx     = byte_done;
  assign evt_new.txc    = txc_set | wc_set;
  assign evt_new.dre    = 1'b0;
  assign evt_new.sel    = sel_trig;
  assign evt_new.unused = 3'h0;
  assign evt_new.ovf    = ovf_set;

  // Level request keeps firing until data is written or disabled
  assign irq_out = (|(evt_ff & mask_ff)) | (mask_ff.dre & view.dre);

  ////////////////////////////////////////////////////////////////////////
  // Control, mask and event status
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_ff <= CTRL_RESET;
      mask_ff <= FLAGS_RESET;
      evt_ff  <= FLAGS_RESET;
    end else begin
      if (do_wr & hit_ctrl) begin
        ctrl_ff <= ctrl_t'(wbyte[3:0]);
      end
      if (sel_trig) begin
        ctrl_ff.master <= 1'b0;
      end
      if (do_wr & hit_mask) begin
        mask_ff <= wbyte & 8'hF1;
      end
      // New events win over the clearing read
      evt_ff <= ((do_rd & hit_evt) ? FLAGS_RESET : evt_ff) | evt_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift engine
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_ff   <= LINK_IDLE;
      tx_sh_ff   <= BYTE_ZERO;
      rx_sh_ff   <= BYTE_ZERO;
      rx_last_ff <= BYTE_ZERO;
      bit_cnt_ff <= FIRST_BIT;
      div_ff     <= 8'h00;
      sck_ff     <= 1'b0;
    end else begin
      div_ff <= (tick | ~run) ? 8'h00 : div_ff + 8'h01;
      if (tick) begin
        sck_ff <= ~sck_ff;
      end
      if (sample_ev) begin
        rx_sh_ff   <= rx_byte;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
      if (byte_done & ~buf_mode) begin
        rx_last_ff <= rx_byte;
      end
      if (load) begin
        tx_sh_ff <= ld_val;
        state_ff <= LINK_SHIFT;
      end else begin
        if (shift_ev & (bit_cnt_ff != FIRST_BIT)) begin
          tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
        end
        if (byte_done | sel_trig) begin
          state_ff <= LINK_IDLE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tx buffer and flags; data write clear wins over hardware tx-empty set
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_buf_ff   <= BYTE_ZERO;
      tx_full_ff  <= 1'b0;
      tx_empty_ff <= 1'b0;
      rx_cnt_ff   <= RX_EMPTY;
      rx_mem_ff   <= '{default: BYTE_ZERO};
    end else begin
      if (move_ld) begin
        tx_full_ff  <= 1'b0;
        tx_empty_ff <= 1'b1;
      end
      if (data_wr) begin
        tx_empty_ff <= 1'b0;
        if (buf_mode) begin
          tx_buf_ff  <= wbyte;
          tx_full_ff <= 1'b1;
        end
      end
      rx_cnt_ff    <= nxt_rx_cnt;
      rx_mem_ff[0] <= nxt_mem0;
      rx_mem_ff[1] <= nxt_mem1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      xfer_done_ff       <= 1'b0;
      select_trigger_ff  <= 1'b0;
      write_collision_ff <= 1'b0;
      wc_arm_ff          <= 1'b0;
      gen_ff             <= 1'b0;
      gen_arm_ff         <= 1'b0;
      rx_overflow_ff     <= 1'b0;
      ovf_pend_ff        <= 1'b0;
    end else begin
      // Writing one clears; the overflow bit in a write is ignored
      xfer_done_ff <= txc_set |
        (xfer_done_ff & ~(flag_wr & wbyte[6]));
      select_trigger_ff <= (sel_trig & buf_mode) |
        (select_trigger_ff & ~(flag_wr & wbyte[4]));
      // Read-then-access clear, armed only by a read that saw it set
      if (flag_rd & write_collision_ff) begin
        wc_arm_ff <= 1'b1;
      end else if (data_acc) begin
        wc_arm_ff <= 1'b0;
      end
      write_collision_ff <= wc_set |
        (write_collision_ff & ~(wc_arm_ff & data_acc));
      if (flag_rd & gen_ff) begin
        gen_arm_ff <= 1'b1;
      end else if (data_acc) begin
        gen_arm_ff <= 1'b0;
      end
      gen_ff <= (~buf_mode & (byte_done | sel_trig)) |
        (gen_ff & ~(gen_arm_ff & data_acc));
      ovf_pend_ff <= (ovf_hit & ~ovf_now) |
        (ovf_pend_ff & ~xfer_start & ~data_rd);
      rx_overflow_ff <= ovf_set |
        (rx_overflow_ff & ~data_rd);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_dre_write_clear:
  assert property (@(posedge clk_in) disable iff (srst_in)
    data_wr |=> !tx_empty_ff) else $error("tx-empty not cleared");

  a_dre_nonbuf_zero:
  assert property (@(posedge clk_in) disable iff (srst_in)
    !buf_mode |-> !view.dre) else $error("tx-empty set unbuffered");

  a_write_collision_flag_set:
  assert property (@(posedge clk_in) disable iff (srst_in)
    data_wr && !buf_mode && busy |=> write_collision_ff && !load)
    else $error("collision missed");

  a_write_collision_flag_hold:
  assert property (@(posedge clk_in) disable iff (srst_in)
    write_collision_ff && !wc_arm_ff |=> write_collision_ff)
    else $error("collision cleared early");

  a_txc_set:
  assert property (@(posedge clk_in) disable iff (srst_in)
    txc_set |=> xfer_done_ff ##1 (xfer_done_ff || $past(flag_wr)))
    else $error("transfer done lost");

  a_sel_trigger:
  assert property (@(posedge clk_in) disable iff (srst_in)
    sel_trig && buf_mode |=> select_trigger_ff && !ctrl_ff.master)
    else $error("select trigger wrong");

  a_ovf_clear:
  assert property (@(posedge clk_in) disable iff (srst_in)
    rx_overflow_ff && !data_rd && !ovf_set |=> rx_overflow_ff)
    else $error("overflow dropped");

  a_rx_pop:
  assert property (@(posedge clk_in) disable iff (srst_in)
    pop && !push && rx_cnt_ff == RX_FULL |=>
      rx_cnt_ff == RX_ONE && rx_mem_ff[1] == $past(rx_mem_ff[0]))
    else $error("rx pop wrong");

  a_irq_dre:
  assert property (@(posedge clk_in) disable iff (srst_in)
    view.dre && mask_ff.dre |-> irq_out) else $error("irq missing");

  a_load_start:
  assert property (@(posedge clk_in) disable iff (srst_in)
    direct_ld |=> state_ff == LINK_SHIFT && tx_sh_ff == $past(wbyte))
    else $error("transfer not started");

  a_byte_flag:
  assert property (@(posedge clk_in) disable iff (srst_in)
    byte_done && !buf_mode |=> gen_ff) else $error("byte flag missed");

  a_flag_unused:
  assert property (@(posedge clk_in) disable iff (srst_in)
    avs_read_in && ack_ff && hit_flag |-> avs_readdata_out[3:1] == 3'h0)
    else $error("unused flag bits set");

endmodule
`default_nettype wire

// ==== common/spi_flags_pkg.sv ====
package spi_flags_pkg;

  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 5;
  localparam int RX_DEPTH = 2;

  // Byte addresses of the registers
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_DATA   = 5'h04;
  localparam logic [4:0] OFS_FLAGS  = 5'h08;
  localparam logic [4:0] OFS_MASK   = 5'h0C;
  localparam logic [4:0] OFS_EVENTS = 5'h10;

  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [1:0] RX_EMPTY = 2'h0;
  localparam logic [1:0] RX_ONE   = 2'h1;
  localparam logic [1:0] RX_FULL  = 2'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Timing: master shift clock half period
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_HALF_NS   = 400;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 SCK_HALF_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic buffered_mode_enable;
    logic select_disable;
    logic master;
    logic enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 4'h0;

  // Layout shared by flags, event status and mask registers
  typedef struct packed {
    logic       rx;
    logic       txc;
    logic       dre;
    logic       sel;
    logic [2:0] unused;
    logic       ovf;
  } flags_t;

  localparam flags_t FLAGS_RESET = 8'h00;

  typedef enum {LINK_IDLE, LINK_SHIFT} link_state_t;

  function automatic logic reg_hit(input logic [4:0] addr,
                                   input logic [4:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

endpackage

// ==== design/link_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
  parameter int            W         = 1,
  parameter logic [W-1:0]  RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  // Asynchronous pins
  input  wire logic [W-1:0] async_in,
  // Synchronised level and edges
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
      prev_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out  = sync_ff & ~prev_ff;
  assign fall_out  = ~sync_ff & prev_ff;

endmodule
`default_nettype wire

// ==== tb/spi_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  // Serial link
  input  wire logic sck_line_in,
  input  wire logic sdo_in,
  output logic      sdi_out,
  output logic      sck_out,
  output logic      select_n_out
);
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  int         bits;
  logic       busy;
  logic [7:0] got_q[$];

  initial begin
    sck_out = 1'b0;
    select_n_out = 1'b1;
    sdi_out = 1'b0;
    busy = 1'b0;
    bits = 0;
  end

  // Idle data line toggles so a stale bit never passes for data
  always #100 if (!busy) sdi_out = ~sdi_out;

  task automatic load(input logic [7:0] b);
    tx_ff = b;
    bits = 0;
    busy = 1'b1;
    sdi_out = b[7];
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Mode 0: sample on rising, shift on falling, MSB first
  always @(posedge sck_line_in) if (busy) begin
    rx_ff = {rx_ff[6:0], sdo_in};
    bits++;
    if (bits == 8) got_q.push_back(rx_ff);
  end

  always @(negedge sck_line_in) if (busy) begin
    if (bits == 8) begin
      busy = 1'b0;
    end else begin
      tx_ff = tx_ff << 1;
      sdi_out = tx_ff[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master role: clock stands low outside frames, odd phase offset
  task automatic run_master(input logic [7:0] b);
    #37;
    load(b);
    select_n_out = 1'b0;
    #400;
    repeat (8) begin
      sck_out = 1'b1;
      #400;
      sck_out = 1'b0;
      #400;
    end
    select_n_out = 1'b1;
  endtask

  task automatic pull_select();
    select_n_out = 1'b0;
    #1000;
    select_n_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spi_flags_pkg::*;
  logic              clk_in;
  logic              srst_in;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              irq;
  logic              sck_o;
  logic              sck_oe;
  logic              sdo;
  logic              sdo_oe;
  logic              sck_far;
  logic              select_n;
  logic              sdi;
  wire logic         sck_line;
  wire logic         sdo_line;
  int                n_errors;
  int                samples_checked;
  int                cycles;
  logic [7:0]        b0;
  logic [7:0]        b1;
  logic [7:0]        exp_rx[$];

  assign sck_line = sck_oe ? sck_o : sck_far;
  // Undriven data line shows garbage, not the last bit
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  spi_flags_data #(.HALF_CYC(4)) u_dut (
    .clk_in(clk_in), .srst_in(srst_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_byteenable_in(avs_byteenable),
    .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .irq_out(irq),
    .sck_in(sck_line), .select_n_in(select_n), .sdi_in(sdi),
    .sck_out(sck_o), .sck_oe_out(sck_oe), .sdo_out(sdo),
    .sdo_oe_out(sdo_oe));

  spi_far_end u_far (.sck_line_in(sck_line), .sdo_in(sdo_line),
                     .sdi_out(sdi), .sck_out(sck_far),
                     .select_n_out(select_n));

  always #50 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] e,
                           input string what);
    samples_checked++;
    if (got !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, e);
    end
  endtask

  // Interrupt is a level: look at it mid-cycle, after edge updates land
  task automatic check_irq(input logic e, input string what);
    @(negedge clk_in);
    samples_checked++;
    if (irq !== e) begin
      n_errors++;
      $display("wrong value at %0t: irq %s", $time, what);
    end
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      $display("wrong value at %0t: run timed out", $time);
      report_and_stop();
    end
  end

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    @(posedge clk_in);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      @(posedge clk_in);
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check_val(8'(n), 8'h01, "wait states");
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] e,
                     input string what);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check_val(q, e, what);
  endtask

  // Far master sends one byte; model keeps at most two received
  task automatic far_byte(input logic [7:0] r);
    u_far.run_master(r);
    if (exp_rx.size() < RX_DEPTH) exp_rx.push_back(r);
    repeat (8) @(posedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    srst_in = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = '0;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(32'hc38c45c1));
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rdc(OFS_FLAGS, 8'h00, "flags at reset");
    rdc(OFS_DATA, 8'h00, "data at reset");
    rdc(5'h14, 8'h00, "unmapped read");
    avs_byteenable <= 4'h0;
    wr(OFS_MASK, 8'hFF);
    avs_byteenable <= 4'hF;
    rdc(OFS_MASK, 8'h00, "lane off write");
    // Unbuffered master: send, collide, receive
    wr(OFS_MASK, 8'h80);
    wr(OFS_CTRL, 8'h03);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    u_far.load(b1);
    wr(OFS_DATA, b0);
    repeat (10) @(posedge clk_in);
    check_val({7'h00, sck_oe}, 8'h01, "clock driven");
    check_val({7'h00, sdo_oe}, 8'h01, "data driven");
    wr(OFS_DATA, ~b0);
    for (int k = 0; k < 2000 && u_far.got_q.size() == 0; k++)
      @(posedge clk_in);
    repeat (8) @(posedge clk_in);
    check_val(8'(u_far.got_q.size()), 8'h01, "bytes on wire");
    check_val(u_far.got_q.pop_front(), b0, "byte on wire");
    check_irq(1'b1, "byte done");
    wr(OFS_MASK, 8'h00);
    check_irq(1'b0, "masked");
    wr(OFS_MASK, 8'h80);
    check_irq(1'b1, "unmasked");
    rdc(OFS_EVENTS, 8'hC0, "events");
    rdc(OFS_EVENTS, 8'h00, "events cleared");
    check_irq(1'b0, "after status read");
    rdc(OFS_DATA, b1, "no clear without flag read");
    rdc(OFS_FLAGS, 8'hC0, "flags after byte");
    rdc(OFS_DATA, b1, "received byte");
    rdc(OFS_FLAGS, 8'h00, "flags cleared");
    // Buffered slave: queue, transfer, overflow, pop
    wr(OFS_MASK, 8'h20);
    wr(OFS_CTRL, 8'h09);
    rdc(OFS_FLAGS, 8'h00, "empty flag starts low");
    b0 = 8'($urandom);
    wr(OFS_DATA, b0);
    rdc(OFS_FLAGS, 8'h20, "byte moved to shifter");
    check_irq(1'b1, "tx empty");
    b1 = 8'($urandom);
    fork
      far_byte(8'($urandom));
      begin
        repeat (20) @(posedge clk_in);
        wr(OFS_DATA, b1);
        rdc(OFS_FLAGS, 8'h00, "byte waiting");
        check_irq(1'b0, "data written");
      end
    join
    rdc(OFS_FLAGS, 8'hA0, "next byte pending");
    far_byte(8'($urandom));
    check_val(8'(u_far.got_q.size()), 8'h02, "queued count");
    check_val(u_far.got_q.pop_front(), b0, "first queued byte");
    check_val(u_far.got_q.pop_front(), b1, "second queued byte");
    rdc(OFS_FLAGS, 8'hE0, "transfer done");
    far_byte(8'($urandom));
    rdc(OFS_FLAGS, 8'hE0, "overflow deferred");
    far_byte(8'($urandom));
    u_far.got_q.delete();
    rdc(OFS_FLAGS, 8'hE1, "overflow");
    rdc(OFS_FLAGS, 8'hE1, "overflow holds");
    wr(OFS_FLAGS, 8'h4E);
    rdc(OFS_FLAGS, 8'hA1, "done cleared");
    rdc(OFS_DATA, exp_rx.pop_front(), "older entry");
    rdc(OFS_FLAGS, 8'hA0, "overflow gone");
    rdc(OFS_DATA, exp_rx.pop_front(), "moved entry");
    rdc(OFS_FLAGS, 8'h20, "rx empty");
    // Select pulled low while master, then with select disabled
    wr(OFS_CTRL, 8'h0B);
    u_far.pull_select();
    repeat (6) @(posedge clk_in);
    rdc(OFS_CTRL, 8'h09, "master dropped");
    check_val({7'h00, sck_oe}, 8'h00, "clock released");
    check_val({7'h00, sdo_oe}, 8'h00, "data released");
    rdc(OFS_FLAGS, 8'h30, "select trigger");
    wr(OFS_FLAGS, 8'h10);
    rdc(OFS_FLAGS, 8'h20, "trigger cleared");
    wr(OFS_CTRL, 8'h0F);
    u_far.pull_select();
    repeat (6) @(posedge clk_in);
    rdc(OFS_CTRL, 8'h0F, "master kept");
    rdc(OFS_FLAGS, 8'h20, "no trigger");
    report_and_stop();
  end
endmodule
`default_nettype wire
